// File: inc/fetch_pkg.sv
// constants and types for the instruction fetch front end
package fetch_pkg;
   localparam int PC_W = 12;
   localparam int PROG_WORDS = 4096;
   localparam int PROG_BYTES = 8192;
   localparam int INSTR_W = 16;
   localparam int DADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int DMEM_BYTES = 256;
   localparam int STACK_DEPTH = 8;
   localparam int CORE_CLK_HZ = 1000000;
   localparam int XTAL_CLK_HZ = 32768;
   localparam int STEPS_PER_CYCLE = 4;
   localparam int STEPS_PER_CLK = 2;
   // mclk cycles per step: core clock period over two steps
   localparam int MCLK_HZ = 20000000;
   localparam int STEP_MCLKS = MCLK_HZ / (CORE_CLK_HZ * STEPS_PER_CLK);
   localparam logic [PC_W-1:0] PC_RESET = 12'h000;
   // opcode field: bits 15:12 class, bits 7:0 direct address or immediate
   localparam int OP_HI = 15;
   localparam int OP_LO = 12;
   localparam int FLD_HI = 7;
   localparam int FLD_LO = 0;
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_MOVLW = 4'h1;
   localparam logic [3:0] OP_MOVWF = 4'h2;
   localparam logic [3:0] OP_MOVFW = 4'h3;
   localparam logic [3:0] OP_CALL = 4'h8;
   localparam logic [3:0] OP_GOTO = 4'h9;
   localparam logic [3:0] OP_RET = 4'hA;
   typedef enum logic [3:0] {
      ST_FETCH = 4'b0001,
      ST_DECODE = 4'b0010,
      ST_EXEC = 4'b0100,
      ST_WBACK = 4'b1000
   } step_t;
endpackage

// File: hw/return_stack.sv
// circular return-address stack; full push drops the oldest entry
`timescale 1ns/10ps
module return_stack
   import fetch_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH,
   parameter int W = PC_W
) (
   input wire logic i_mclk, // clock
   input wire logic i_sys_rst, // sync reset
   input wire logic i_ce, // clock enable
   input wire logic i_push, // push request
   input wire logic i_pop, // pop request
   input wire logic [W-1:0] i_data, // pushed pointer
   output logic [W-1:0] o_top // current top entry
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two >= 2");
   end
   logic [W-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wp_reg, wp_next;
   logic [AW:0] cnt_reg, cnt_next;
   always_comb begin
      wp_next = wp_reg;
      cnt_next = cnt_reg;
      if (i_push) begin
         wp_next = wp_reg + 1'b1;
         // wraps over oldest entry silently
         if (cnt_reg != (AW+1)'(DEPTH)) cnt_next = cnt_reg + 1'b1;
      end else if (i_pop && cnt_reg != '0) begin
         wp_next = wp_reg - 1'b1;
         cnt_next = cnt_reg - 1'b1;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         wp_reg <= '0;
         cnt_reg <= '0;
      end else if (i_ce) begin
         wp_reg <= wp_next;
         cnt_reg <= cnt_next;
         if (i_push) mem_reg[wp_reg] <= i_data;
      end
   end
   assign o_top = mem_reg[wp_reg - 1'b1];
endmodule

// File: hw/fetch_core.sv
// instruction fetch, decode and sequencing front end
`timescale 1ns/10ps
module fetch_core
   import fetch_pkg::*;
#(
   parameter int STEP_CLKS = STEP_MCLKS
) (
   input wire logic i_mclk, // 20 MHz clock
   input wire logic i_sys_rst, // sync reset, active high
   input wire logic i_ce, // clock enable
   input wire logic [INSTR_W-1:0] i_prog_data, // program store word
   input wire logic [DATA_W-1:0] i_dmem_rdata, // data memory read data
   output logic [PC_W-1:0] o_prog_addr, // program store address
   output logic o_prog_rd, // program read strobe
   output logic [DADDR_W-1:0] o_dmem_addr, // data memory address
   output logic [DATA_W-1:0] o_dmem_wdata, // data memory write data
   output logic o_dmem_rd, // data memory read strobe
   output logic o_dmem_wr, // data memory write strobe
   output logic [DATA_W-1:0] o_work, // working register
   output logic [INSTR_W-1:0] o_ir, // instruction register
   output logic [3:0] o_step // current step, one-hot
);
   initial begin
      if (STEP_CLKS < 1) $error("STEP_CLKS must be at least 1");
      if (PROG_WORDS != (1 << PC_W) || PROG_BYTES != 2 * PROG_WORDS) $error("pc width mismatch");
      if (DMEM_BYTES != (1 << DADDR_W)) $error("direct address width mismatch");
   end
   localparam int SC_W = $clog2(STEP_CLKS + 1);

   function automatic logic is_xfer(input logic [3:0] op);
      return op == OP_CALL || op == OP_GOTO;
   endfunction

   step_t step_reg, step_next;
   logic [SC_W-1:0] sc_reg, sc_next;
   logic [PC_W-1:0] pc_reg, pc_next;
   logic [INSTR_W-1:0] ir_reg, ir_next;
   logic [DATA_W-1:0] w_reg, w_next;
   logic flush_reg, flush_next;
   logic [PC_W-1:0] tgt_reg, tgt_next;
   logic [PC_W-1:0] paddr_reg, paddr_next;
   logic prd_reg, prd_next;
   logic [DADDR_W-1:0] daddr_reg, daddr_next;
   logic [DATA_W-1:0] dwd_reg, dwd_next;
   logic drd_reg, drd_next, dwr_reg, dwr_next;
   logic push, pop, adv;
   logic [PC_W-1:0] stk_top;
   logic [3:0] op;
   logic [DADDR_W-1:0] fld;

   // split the latched word
   assign op = ir_reg[OP_HI:OP_LO];
   assign fld = ir_reg[FLD_HI:FLD_LO];

   return_stack #(.DEPTH(STACK_DEPTH), .W(PC_W)) u_stack (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_push(push),
      .i_pop(pop),
      .i_data(pc_reg),
      .o_top(stk_top)
   );

   // step timer: one step per half core clock
   always_comb begin
      adv = sc_reg == SC_W'(STEP_CLKS - 1);
      sc_next = adv ? '0 : sc_reg + 1'b1;
      step_next = step_reg;
      if (adv) begin
         case (step_reg)
            ST_FETCH: step_next = ST_DECODE;
            ST_DECODE: step_next = ST_EXEC;
            ST_EXEC: step_next = ST_WBACK;
            ST_WBACK: step_next = ST_FETCH;
            default: step_next = ST_FETCH;
         endcase
      end
   end

   always_comb begin
      pc_next = pc_reg;
      ir_next = ir_reg;
      w_next = w_reg;
      flush_next = flush_reg;
      tgt_next = tgt_reg;
      paddr_next = paddr_reg;
      prd_next = 1'b0;
      daddr_next = daddr_reg;
      dwd_next = dwd_reg;
      drd_next = 1'b0;
      dwr_next = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      if (adv) begin
         case (step_reg)
            ST_FETCH: begin
               // present pc and advance; 12-bit wrap spans 4k
               paddr_next = pc_reg;
               prd_next = 1'b1;
               // the dead slot still fetches the next word, so the target lands only now and is never lost
               pc_next = flush_reg ? tgt_reg : pc_reg + 1'b1;
            end
            ST_DECODE: begin
               // a flushed cycle is the second cycle of a transfer
               ir_next = flush_reg ? {OP_NOP, 12'h000} : i_prog_data;
               flush_next = 1'b0;
               if (!flush_reg) begin
                  daddr_next = i_prog_data[FLD_HI:FLD_LO];
                  drd_next = i_prog_data[OP_HI:OP_LO] == OP_MOVFW;
               end
            end
            ST_EXEC: begin
               case (op)
                  OP_CALL: begin
                     push = 1'b1; // pc already points past the call
                     tgt_next = ir_reg[PC_W-1:0];
                  end
                  OP_GOTO: tgt_next = ir_reg[PC_W-1:0];
                  OP_RET: begin
                     pop = 1'b1;
                     tgt_next = stk_top;
                  end
                  default: ;
               endcase
               flush_next = is_xfer(op) || op == OP_RET;
            end
            ST_WBACK: begin
               // immediate to work reg or direct memory access
               case (op)
                  OP_MOVLW: w_next = fld;
                  OP_MOVFW: w_next = i_dmem_rdata;
                  OP_MOVWF: begin
                     daddr_next = fld;
                     dwd_next = w_reg;
                     dwr_next = 1'b1;
                  end
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         step_reg <= ST_FETCH;
         sc_reg <= '0;
         pc_reg <= PC_RESET;
         ir_reg <= '0;
         w_reg <= '0;
         flush_reg <= 1'b0;
         tgt_reg <= PC_RESET;
         paddr_reg <= PC_RESET;
         prd_reg <= 1'b0;
         daddr_reg <= '0;
         dwd_reg <= '0;
         drd_reg <= 1'b0;
         dwr_reg <= 1'b0;
      end else if (i_ce) begin
         step_reg <= step_next;
         sc_reg <= sc_next;
         pc_reg <= pc_next;
         ir_reg <= ir_next;
         w_reg <= w_next;
         flush_reg <= flush_next;
         tgt_reg <= tgt_next;
         paddr_reg <= paddr_next;
         prd_reg <= prd_next;
         daddr_reg <= daddr_next;
         dwd_reg <= dwd_next;
         drd_reg <= drd_next;
         dwr_reg <= dwr_next;
      end
   end

   assign o_prog_addr = paddr_reg;
   assign o_prog_rd = prd_reg;
   assign o_dmem_addr = daddr_reg;
   assign o_dmem_wdata = dwd_reg;
   assign o_dmem_rd = drd_reg;
   assign o_dmem_wr = dwr_reg;
   assign o_work = w_reg;
   assign o_ir = ir_reg;
   assign o_step = step_reg;
endmodule

// File: verification/fetch_core_checker.sv
// port assertions for the fetch front end
`timescale 1ns/10ps
module fetch_core_checker
   import fetch_pkg::*;
#(
   parameter int STEP_CLKS = STEP_MCLKS
) (
   input wire logic i_mclk, // clk
   input wire logic i_sys_rst, // rst
   input wire logic i_ce, // en
   input wire logic [INSTR_W-1:0] i_prog_data, // word
   input wire logic [DATA_W-1:0] i_dmem_rdata, // rdata
   input wire logic [PC_W-1:0] o_prog_addr, // pc
   input wire logic o_prog_rd, // fetch
   input wire logic [DADDR_W-1:0] o_dmem_addr, // addr
   input wire logic [DATA_W-1:0] o_dmem_wdata, // wdata
   input wire logic o_dmem_rd, // rd
   input wire logic o_dmem_wr, // wr
   input wire logic [DATA_W-1:0] o_work, // work
   input wire logic [INSTR_W-1:0] o_ir, // ir
   input wire logic [3:0] o_step // step
);
   localparam int STP = STEP_CLKS;
   localparam int CYC = 4 * STEP_CLKS;
   logic was_xfer;
   // at a fresh fetch the ir still holds the previous word; a transfer there means this slot is dead
   assign was_xfer = o_ir[OP_HI:OP_LO] == OP_CALL || o_ir[OP_HI:OP_LO] == OP_GOTO || o_ir[OP_HI:OP_LO] == OP_RET;
   default clocking @(posedge i_mclk); endclocking
   // a low enable stretches the steps, so timed checks only count runs of enabled edges
   default disable iff (i_sys_rst || !i_ce);
   sequence s_steps;
      o_step == ST_DECODE ##STP o_step == ST_EXEC ##STP o_step == ST_WBACK ##STP o_step == ST_FETCH;
   endsequence
   property p_steps;
      o_prog_rd |-> s_steps;
   endproperty
   a_steps: assert property (p_steps) else $error("step order wrong");
   property p_rd_pulse;
      o_prog_rd |=> !o_prog_rd;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("fetch strobe too long");
   property p_period;
      o_prog_rd |-> ##CYC o_prog_rd;
   endproperty
   a_period: assert property (p_period) else $error("fetch spacing wrong");
   property p_ir;
      o_prog_rd && !was_xfer |-> ##STP o_ir == $past(i_prog_data);
   endproperty
   a_ir: assert property (p_ir) else $error("ir not latched");
   property p_flush;
      o_prog_rd && was_xfer |-> ##STP o_ir == {OP_NOP, 12'h000};
   endproperty
   a_flush: assert property (p_flush) else $error("dead slot not discarded");
   property p_wr;
      o_dmem_wr |-> o_ir[OP_HI:OP_LO] == OP_MOVWF && o_dmem_addr == o_ir[FLD_HI:FLD_LO] && o_dmem_wdata == o_work;
   endproperty
   a_wr: assert property (p_wr) else $error("bad data write");
   property p_rd;
      o_dmem_rd |-> o_ir[OP_HI:OP_LO] == OP_MOVFW && o_dmem_addr == o_ir[FLD_HI:FLD_LO];
   endproperty
   a_rd: assert property (p_rd) else $error("bad data read");
   property p_reset;
      disable iff (1'b0) i_sys_rst |=> o_step == ST_FETCH && o_prog_addr == PC_RESET && !o_prog_rd && o_work == 8'h00;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   property p_first;
      $fell(i_sys_rst) |-> ##STP o_prog_rd && o_prog_addr == PC_RESET;
   endproperty
   a_first: assert property (p_first) else $error("first fetch wrong");
   property p_freeze;
      disable iff (i_sys_rst) !i_ce |=> $stable(o_prog_addr) && $stable(o_prog_rd) && $stable(o_step)
         && $stable(o_ir) && $stable(o_work) && $stable(o_dmem_addr);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");
endmodule
bind fetch_core fetch_core_checker #(.STEP_CLKS(STEP_CLKS)) chk (.*);

// File: verification/fetch_mem_model.sv
// program and data memory model for the fetch front end
`timescale 1ns/10ps
module fetch_mem_model
   import fetch_pkg::*;
(
   input wire logic i_mclk, // clk
   input wire logic [PC_W-1:0] i_paddr, // pc
   input wire logic i_prd, // fetch
   input wire logic [DADDR_W-1:0] i_daddr, // addr
   input wire logic [DATA_W-1:0] i_wdata, // wdata
   input wire logic i_drd, // rd
   input wire logic i_dwr, // wr
   output logic [INSTR_W-1:0] o_pdata, // word
   output logic [DATA_W-1:0] o_rdata // rdata
);
   logic [INSTR_W-1:0] prog [PROG_WORDS];
   logic [DATA_W-1:0] dmem [DMEM_BYTES];
   logic [INSTR_W-1:0] junk = 16'hA5C3;
   // word only valid in its slot; a toggling pattern elsewhere exposes late sampling
   assign o_pdata = i_prd ? prog[i_paddr] : junk;
   initial begin
      o_rdata = 8'h00;
      foreach (dmem[i]) dmem[i] = 8'h00;
   end
   always @(posedge i_mclk) begin
      junk <= ~junk;
      if (i_dwr) dmem[i_daddr] <= i_wdata;
      if (i_drd) o_rdata <= dmem[i_daddr];
   end
endmodule

// File: verification/fetch_core_tb.sv
// self-checking bench for the fetch front end
`timescale 1ns/10ps
module fetch_core_tb;
   import fetch_pkg::*;
   logic i_mclk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_ce = 1'b1;
   logic [INSTR_W-1:0] i_prog_data, o_ir, wd;
   logic [DATA_W-1:0] i_dmem_rdata, o_dmem_wdata, o_work, w_exp;
   logic [DATA_W-1:0] dm [DMEM_BYTES];
   logic [PC_W-1:0] o_prog_addr, pc, pend;
   logic [PC_W-1:0] stk [$];
   logic [DADDR_W-1:0] o_dmem_addr;
   logic [3:0] o_step;
   logic o_prog_rd, o_dmem_rd, o_dmem_wr, pend_v, ce_q;
   int fail_count = 0, compares = 0, cycles = 0, fetches = 0, seed = 32'habc5;
   fetch_core #(.STEP_CLKS(1)) DUT (.*);
   fetch_mem_model mem (.i_mclk(i_mclk), .i_paddr(o_prog_addr), .i_prd(o_prog_rd), .i_daddr(o_dmem_addr),
      .i_wdata(o_dmem_wdata), .i_drd(o_dmem_rd), .i_dwr(o_dmem_wr), .o_pdata(i_prog_data), .o_rdata(i_dmem_rdata));
   initial forever #25 i_mclk = ~i_mclk;
   // enable drops on about one edge in four; ce_q remembers whether the last edge moved the design
   always @(posedge i_mclk) begin
      ce_q = i_ce;
      #1 i_ce = ($random(seed) & 3) != 0;
   end
   task check(input logic [15:0] seen, input logic [15:0] exp, input string name);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task end_sim;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // reference sequencer: effects land at fetch time, the slot after a transfer runs as nop
   always @(negedge i_mclk) begin
      if (i_sys_rst) begin
         pc = PC_RESET;
         pend_v = 1'b0;
         w_exp = 8'h00;
         stk.delete();
      end else if (o_prog_rd && ce_q) begin
         fetches++;
         check({4'h0, o_prog_addr}, {4'h0, pc}, "pc");
         check({8'h00, o_work}, {8'h00, w_exp}, "work");
         wd = mem.prog[pc];
         pc = pc + 1'b1;
         if (pend_v) begin
            pc = pend;
            pend_v = 1'b0;
         end else case (wd[15:12])
            OP_MOVLW: w_exp = wd[7:0];
            OP_MOVWF: dm[wd[7:0]] = w_exp;
            OP_MOVFW: w_exp = dm[wd[7:0]];
            OP_CALL, OP_GOTO, OP_RET: begin
               pend_v = 1'b1;
               pend = (wd[15:12] == OP_RET) ? stk.pop_back() : wd[11:0];
               if (wd[15:12] == OP_CALL && stk.size() == STACK_DEPTH) stk.pop_front();
               if (wd[15:12] == OP_CALL) stk.push_back(pc);
            end
            default: ;
         endcase
      end
   end
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         $display("timeout");
         end_sim;
      end
   end
   initial begin
      foreach (dm[i]) dm[i] = 8'h00;
      for (int i = 0; i < PROG_WORDS; i++) mem.prog[i] = {2'b00, 2'($random(seed)), 4'h0, 8'($random(seed))};
      // nine nested calls overflow the eight-deep stack, then eight returns
      mem.prog[0] = {OP_CALL, 12'h200};
      for (int i = 0; i < 8; i++) begin
         mem.prog[12'h200 + 2 * i] = {OP_CALL, 12'(12'h202 + 2 * i)};
         mem.prog[12'h201 + 2 * i] = {OP_RET, 12'h000};
      end
      mem.prog[12'h210] = {OP_RET, 12'h000};
      mem.prog[12'h201] = {OP_GOTO, 12'h010};
      repeat (16) @(posedge i_mclk);
      #1 i_sys_rst = 1'b0;
      wait (fetches >= 300);
      $display("test calls and random code done");
      @(negedge i_mclk iff o_step === ST_FETCH);
      @(posedge i_mclk);
      #1 i_sys_rst = 1'b1;
      @(posedge i_mclk);
      #1 i_sys_rst = 1'b0;
      fetches = 0;
      wait (fetches >= 40);
      $display("test mid-run reset done");
      end_sim;
   end
endmodule
